// ---- rtl/uaf_top.sv ----
// Two-channel serial port with multiprocessor address filter and APB registers
`timescale 1ns/1ps
`default_nettype none
module uaf_top (
    input  wire logic                       clk,
    input  wire logic                       rst,
    input  wire logic                       psel,
    input  wire logic                       penable,
    input  wire logic                       pwrite,
    input  wire logic [uaf_pkg::ADDR_W-1:0] paddr,
    input  wire logic [31:0]                pwdata,
    output logic      [31:0]                prdata,
    output logic                            pready,
    output logic                            pslverr,
    input  wire logic [1:0]                 rate_tick,
    input  wire logic [1:0]                 rxd_pin,
    output logic      [1:0]                 rxd_out,
    output logic      [1:0]                 rxd_oe,
    output logic      [1:0]                 txd,
    output logic                            irq
);
    import uaf_pkg::*;

    // ========================================================================
    // Helpers
    // ========================================================================
    function automatic logic [3:0] reg_sel(input logic [ADDR_W-1:0] a);
        logic [ADDR_W-1:0] d;
        d = a - OFS_CTRL0;
        if ((a < OFS_CTRL0) || (a > OFS_IMASK) || (a[1:0] != 2'b00))
            reg_sel = SEL_NONE;
        else
            reg_sel = d[5:2];
    endfunction : reg_sel

    function automatic logic frame_accept(
        input uaf_ctrl_s  c,
        input uaf_rx_s    w,
        input logic [7:0] sa,
        input logic [7:0] sm
    );
        logic       hit;
        logic [7:0] bcast;
        bcast = sa | sm;
        hit   = (((w.data ^ sa) & sm) == 8'h00)
             || ((w.data & bcast) == bcast);
        case ({c.mode_select_high, c.mode_select_low})
            MODE_SHIFT:
                frame_accept = 1'b1;
            MODE_UART8:
                frame_accept = !c.multiproc_enable || w.stop_ok;
            default:
                frame_accept = !c.multiproc_enable || (w.ninth && hit);
        endcase
    endfunction : frame_accept

    // ========================================================================
    // State
    // ========================================================================
    logic [1:0]  rxd_s1_reg, rxd_s2_reg;
    uaf_ctrl_s   ctrl_reg   [NCH];
    uaf_ctrl_s   ctrl_next  [NCH];
    logic [7:0]  slave_address_reg  [NCH];
    logic [7:0]  slave_address_next [NCH];
    logic [7:0]  smask_reg  [NCH];
    logic [7:0]  smask_next [NCH];
    logic [7:0]  rxbuf_reg  [NCH];
    logic [7:0]  rxbuf_next [NCH];
    logic [7:0]  txbyte_reg [NCH];
    logic [7:0]  txbyte_next[NCH];
    logic [1:0]  txgo_reg, txgo_next;
    logic [3:0]  status_reg, status_next, status_set;
    logic [3:0]  imask_reg, imask_next;
    logic        irq_next, div_reg, div_next;
    logic [31:0] prdata_next;
    logic        pready_next, pslverr_next;
    logic [3:0]  sel;
    logic        wr_fire;
    logic [7:0]  rd;
    uaf_mode_e   chan_mode  [NCH];
    logic [1:0]  os_tick, rx_start0, rx_arm, tx_ninth;
    logic [1:0]  rx_valid, tx_done_p;
    uaf_rx_s     rx_word    [NCH];

    // ========================================================================
    // Channels
    // ========================================================================
    genvar g;
    for (g = 0; g < NCH; g++)
    begin : g_chan
        uaf_chan u_chan (
            .clk       (clk),
            .rst       (rst),
            .mode      (chan_mode[g]),
            .os_tick   (os_tick[g]),
            .rxd_in    (rxd_s2_reg[g]),
            .rx_arm    (rx_arm[g]),
            .rx_start0 (rx_start0[g]),
            .tx_go     (txgo_reg[g]),
            .tx_byte   (txbyte_reg[g]),
            .tx_ninth  (tx_ninth[g]),
            .rx_valid  (rx_valid[g]),
            .rx_word   (rx_word[g]),
            .tx_done   (tx_done_p[g]),
            .txd       (txd[g]),
            .rxd_out   (rxd_out[g]),
            .rxd_oe    (rxd_oe[g])
        );
    end

    // ========================================================================
    // Next-state logic
    // ========================================================================
    always_comb
    begin
        sel        = reg_sel(paddr);
        wr_fire    = psel && penable && pready && pwrite;
        status_set = 4'h0;
        div_next   = ~div_reg;
        for (int i = 0; i < NCH; i++)
        begin
            chan_mode[i] = uaf_mode_e'({ctrl_reg[i].mode_select_high,
                                        ctrl_reg[i].mode_select_low});
            // Fixed rates: shift mode clk/16, 9-bit fixed clk/32 per bit
            case (chan_mode[i])
                MODE_SHIFT:  os_tick[i] = 1'b1;
                MODE_UART9F: os_tick[i] = div_reg;
                default:     os_tick[i] = rate_tick[i];
            endcase
            rx_arm[i]    = ctrl_reg[i].rx_enable;
            // Shift-mode reception starts while rx_done_flag is clear, also right after a byte ends, before its flag is set
            rx_start0[i] = ctrl_reg[i].rx_enable && !ctrl_reg[i].rx_done_flag;
            tx_ninth[i]  = ctrl_reg[i].tx_ninth_bit;
            ctrl_next[i]   = ctrl_reg[i];
            slave_address_next[i]  = slave_address_reg[i];
            smask_next[i]  = smask_reg[i];
            rxbuf_next[i]  = rxbuf_reg[i];
            txbyte_next[i] = txbyte_reg[i];
            txgo_next[i]   = 1'b0;
            if (wr_fire)
            begin
                if (sel == SEL_CTRL + 4'(i))
                    ctrl_next[i] = uaf_ctrl_s'(pwdata[7:0]);
                if (sel == SEL_ADDR + 4'(i))
                    slave_address_next[i] = pwdata[7:0];
                if (sel == SEL_MASK + 4'(i))
                    smask_next[i] = pwdata[7:0];
                if (sel == SEL_DATA + 4'(i))
                begin
                    txgo_next[i]   = 1'b1;
                    txbyte_next[i] = pwdata[7:0];
                end
            end
            // Hardware sets are applied after the write, so a set wins
            if (tx_done_p[i])
            begin
                ctrl_next[i].tx_done_flag = 1'b1;
                status_set[2*i+IST_TX]    = 1'b1;
            end
            if (rx_valid[i] && ctrl_reg[i].rx_enable
                && frame_accept(ctrl_reg[i], rx_word[i], slave_address_reg[i], smask_reg[i]))
            begin
                ctrl_next[i].rx_done_flag = 1'b1;
                if (chan_mode[i] != MODE_SHIFT)
                    ctrl_next[i].rx_ninth_bit = rx_word[i].ninth;
                rxbuf_next[i]             = rx_word[i].data;
                status_set[2*i+IST_RX]    = 1'b1;
            end
        end
        imask_next  = (wr_fire && sel == SEL_IMASK) ? pwdata[3:0] : imask_reg;
        status_next = (status_reg & ~((wr_fire && sel == SEL_ISTAT) ? pwdata[3:0] : 4'h0))
                    | status_set;
        irq_next    = |(status_next & imask_next);

        // Read data is captured in the setup cycle; access always has one cycle
        case (sel)
            SEL_CTRL:          rd = ctrl_reg[0];
            SEL_CTRL + 4'h1:   rd = ctrl_reg[1];
            SEL_ADDR:          rd = slave_address_reg[0];
            SEL_ADDR + 4'h1:   rd = slave_address_reg[1];
            SEL_MASK:          rd = smask_reg[0];
            SEL_MASK + 4'h1:   rd = smask_reg[1];
            SEL_DATA:          rd = rxbuf_reg[0];
            SEL_DATA + 4'h1:   rd = rxbuf_reg[1];
            SEL_ISTAT:         rd = {4'h0, status_reg};
            SEL_IMASK:         rd = {4'h0, imask_reg};
            default:           rd = 8'h00;
        endcase
        pready_next  = psel && !penable;
        pslverr_next = psel && !penable && (sel == SEL_NONE);
        prdata_next  = (psel && !penable) ? {24'h00_0000, rd} : prdata;
    end

    // ========================================================================
    // Registers
    // ========================================================================
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            rxd_s1_reg <= 2'b11;
            rxd_s2_reg <= 2'b11;
            for (int i = 0; i < NCH; i++)
            begin
                ctrl_reg[i]   <= uaf_ctrl_s'(CTRL_RST);
                slave_address_reg[i]  <= SLAVE_ADDRESS_RST;
                smask_reg[i]  <= SMASK_RST;
                rxbuf_reg[i]  <= 8'h00;
                txbyte_reg[i] <= 8'h00;
            end
            txgo_reg   <= 2'b00;
            status_reg <= 4'h0;
            imask_reg  <= IMASK_RST;
            irq        <= 1'b0;
            div_reg    <= 1'b0;
            prdata     <= 32'h0000_0000;
            pready     <= 1'b0;
            pslverr    <= 1'b0;
        end
        else
        begin
            rxd_s1_reg <= rxd_pin;
            rxd_s2_reg <= rxd_s1_reg;
            for (int i = 0; i < NCH; i++)
            begin
                ctrl_reg[i]   <= ctrl_next[i];
                slave_address_reg[i]  <= slave_address_next[i];
                smask_reg[i]  <= smask_next[i];
                rxbuf_reg[i]  <= rxbuf_next[i];
                txbyte_reg[i] <= txbyte_next[i];
            end
            txgo_reg   <= txgo_next;
            status_reg <= status_next;
            imask_reg  <= imask_next;
            irq        <= irq_next;
            div_reg    <= div_next;
            prdata     <= prdata_next;
            pready     <= pready_next;
            pslverr    <= pslverr_next;
        end
    end

endmodule : uaf_top
`default_nettype wire

// ---- rtl/uaf_pkg.sv ----
// Constants, types and register map of the multiprocessor serial port
package uaf_pkg;

    // ========================================================================
    // Register map (byte addresses, 32-bit aligned words)
    // ========================================================================
    localparam int          ADDR_W    = 12;
    localparam int          NCH       = 2;
    localparam logic [11:0] OFS_CTRL0 = 12'h420;
    localparam logic [11:0] OFS_CTRL1 = 12'h424;
    localparam logic [11:0] OFS_ADDR0 = 12'h428;
    localparam logic [11:0] OFS_ADDR1 = 12'h42C;
    localparam logic [11:0] OFS_MASK0 = 12'h430;
    localparam logic [11:0] OFS_MASK1 = 12'h434;
    localparam logic [11:0] OFS_DATA0 = 12'h438;
    localparam logic [11:0] OFS_DATA1 = 12'h43C;
    localparam logic [11:0] OFS_ISTAT = 12'h440;
    localparam logic [11:0] OFS_IMASK = 12'h444;

    // Word index from the first offset; one per channel for the paired kinds
    localparam logic [3:0]  SEL_CTRL  = 4'h0;
    localparam logic [3:0]  SEL_ADDR  = 4'h2;
    localparam logic [3:0]  SEL_MASK  = 4'h4;
    localparam logic [3:0]  SEL_DATA  = 4'h6;
    localparam logic [3:0]  SEL_ISTAT = 4'h8;
    localparam logic [3:0]  SEL_IMASK = 4'h9;
    localparam logic [3:0]  SEL_NONE  = 4'hF;

    localparam logic [7:0]  CTRL_RST  = 8'h00;
    localparam logic [7:0]  SLAVE_ADDRESS_RST = 8'h00;
    localparam logic [7:0]  SMASK_RST = 8'h00;
    localparam logic [3:0]  IMASK_RST = 4'h0;

    // Status bit of channel n: receive at 2n, transmit at 2n+1
    localparam int          IST_RX    = 0;
    localparam int          IST_TX    = 1;

    // ========================================================================
    // Bit timing, 16 oversampling ticks per bit
    // ========================================================================
    localparam logic [3:0]  OS_MID    = 4'h7;
    localparam logic [3:0]  OS_LAST   = 4'hF;
    localparam logic [3:0]  RX_LAST8  = 4'h7;
    localparam logic [3:0]  RX_LAST9  = 4'h8;
    localparam logic [3:0]  TX_LAST0  = 4'h7;
    localparam logic [3:0]  TX_LAST8  = 4'h9;
    localparam logic [3:0]  TX_LAST9  = 4'hA;

    // ========================================================================
    // Types
    // ========================================================================
    typedef enum logic [1:0] {
        MODE_SHIFT  = 2'b00,
        MODE_UART8  = 2'b01,
        MODE_UART9F = 2'b10,
        MODE_UART9V = 2'b11
    } uaf_mode_e;

    typedef enum logic [3:0] {
        RX_IDLE  = 4'b0001,
        RX_START = 4'b0010,
        RX_DATA  = 4'b0100,
        RX_STOP  = 4'b1000
    } uaf_rx_state_e;

    typedef enum logic [1:0] {
        TX_IDLE  = 2'b01,
        TX_SHIFT = 2'b10
    } uaf_tx_state_e;

    typedef struct packed {
        logic mode_select_high;
        logic mode_select_low;
        logic multiproc_enable;
        logic rx_enable;
        logic tx_ninth_bit;
        logic rx_ninth_bit;
        logic tx_done_flag;
        logic rx_done_flag;
    } uaf_ctrl_s;

    typedef struct packed {
        logic [7:0] data;
        logic       ninth;
        logic       stop_ok;
    } uaf_rx_s;

endpackage : uaf_pkg

// ---- rtl/uaf_chan.sv ----
// One serial channel: frame receiver and transmitter with pin drivers
`timescale 1ns/1ps
`default_nettype none
module uaf_chan (
    input  wire logic               clk,
    input  wire logic               rst,
    input  wire uaf_pkg::uaf_mode_e mode,
    input  wire logic               os_tick,
    input  wire logic               rxd_in,
    input  wire logic               rx_arm,
    input  wire logic               rx_start0,
    input  wire logic               tx_go,
    input  wire logic [7:0]         tx_byte,
    input  wire logic               tx_ninth,
    output logic                    rx_valid,
    output var uaf_pkg::uaf_rx_s    rx_word,
    output logic                    tx_done,
    output logic                    txd,
    output logic                    rxd_out,
    output logic                    rxd_oe
);
    import uaf_pkg::*;

    uaf_rx_state_e rx_state_reg, rx_state_next;
    uaf_tx_state_e tx_state_reg, tx_state_next;
    logic [3:0]    rcnt_reg, rcnt_next, rbit_reg, rbit_next;
    logic [3:0]    tcnt_reg, tcnt_next, tbit_reg, tbit_next;
    logic [8:0]    rsh_reg, rsh_next;
    logic [10:0]   tsh_reg, tsh_next;
    logic          rx_valid_next, tx_done_next;
    logic          txd_next, rxd_out_next, rxd_oe_next;
    uaf_rx_s       rx_word_next;
    logic          nine, shift;
    logic [3:0]    rx_last, tx_last;

    // ========================================================================
    // Receive
    // ========================================================================
    always_comb
    begin
        nine          = (mode == MODE_UART9F) || (mode == MODE_UART9V);
        shift         = (mode == MODE_SHIFT);
        rx_last       = nine ? RX_LAST9 : RX_LAST8;
        rx_state_next = rx_state_reg;
        rcnt_next     = rcnt_reg;
        rbit_next     = rbit_reg;
        rsh_next      = rsh_reg;
        rx_valid_next = 1'b0;
        rx_word_next  = rx_word;
        case (rx_state_reg)
            RX_IDLE:
            begin
                rcnt_next = 4'h0;
                rbit_next = 4'h0;
                if (shift && rx_start0)
                    rx_state_next = RX_DATA;
                else if (!shift && !rxd_in)
                    rx_state_next = RX_START;
            end
            RX_START:
                if (os_tick)
                begin
                    rcnt_next = rcnt_reg + 4'h1;
                    if (rcnt_reg == OS_MID)
                    begin
                        // A start bit gone high by mid-bit was a glitch
                        rcnt_next     = 4'h0;
                        rx_state_next = rxd_in ? RX_IDLE : RX_DATA;
                    end
                end
            RX_DATA:
                if (os_tick)
                begin
                    rcnt_next = rcnt_reg + 4'h1;
                    if (rcnt_reg == OS_LAST)
                    begin
                        rsh_next  = {rxd_in, rsh_reg[8:1]};
                        rbit_next = rbit_reg + 4'h1;
                        if (rbit_reg == rx_last)
                        begin
                            if (shift)
                            begin
                                rx_valid_next        = 1'b1;
                                rx_word_next.data    = rsh_next[8:1];
                                rx_word_next.stop_ok = 1'b1;
                                rx_state_next        = RX_IDLE;
                            end
                            else
                                rx_state_next = RX_STOP;
                        end
                    end
                end
            RX_STOP:
                if (os_tick)
                begin
                    rcnt_next = rcnt_reg + 4'h1;
                    if (rcnt_reg == OS_LAST)
                    begin
                        rx_valid_next        = 1'b1;
                        rx_word_next.data    = nine ? rsh_reg[7:0] : rsh_reg[8:1];
                        rx_word_next.ninth   = nine ? rsh_reg[8] : rxd_in;
                        rx_word_next.stop_ok = rxd_in;
                        rx_state_next        = RX_IDLE;
                    end
                end
            default:
                rx_state_next = RX_IDLE;
        endcase
        if (!rx_arm)
            rx_state_next = RX_IDLE;
    end

    // ========================================================================
    // Transmit and pins
    // ========================================================================
    always_comb
    begin
        tx_last       = shift ? TX_LAST0 : (nine ? TX_LAST9 : TX_LAST8);
        tx_state_next = tx_state_reg;
        tcnt_next     = tcnt_reg;
        tbit_next     = tbit_reg;
        tsh_next      = tsh_reg;
        tx_done_next  = 1'b0;
        case (tx_state_reg)
            TX_IDLE:
            begin
                tcnt_next = 4'h0;
                tbit_next = 4'h0;
                if (tx_go)
                begin
                    tx_state_next = TX_SHIFT;
                    if (shift)
                        tsh_next = {3'b111, tx_byte};
                    else if (nine)
                        tsh_next = {1'b1, tx_ninth, tx_byte, 1'b0};
                    else
                        tsh_next = {2'b11, tx_byte, 1'b0};
                end
            end
            TX_SHIFT:
                if (os_tick)
                begin
                    tcnt_next = tcnt_reg + 4'h1;
                    if (tcnt_reg == OS_LAST)
                    begin
                        tsh_next  = {1'b1, tsh_reg[10:1]};
                        tbit_next = tbit_reg + 4'h1;
                        if (tbit_reg == tx_last)
                        begin
                            tx_done_next  = 1'b1;
                            tx_state_next = TX_IDLE;
                        end
                    end
                end
            default:
                tx_state_next = TX_IDLE;
        endcase
        // Shift mode: data on the rxd pin, shift clock on txd, low half first
        if (shift)
        begin
            rxd_oe_next  = (tx_state_next == TX_SHIFT);
            rxd_out_next = tsh_next[0];
            if (tx_state_next == TX_SHIFT)
                txd_next = tcnt_next[3];
            else if (rx_state_next == RX_DATA)
                txd_next = rcnt_next[3];
            else
                txd_next = 1'b1;
        end
        else
        begin
            rxd_oe_next  = 1'b0;
            rxd_out_next = 1'b1;
            txd_next     = (tx_state_next == TX_SHIFT) ? tsh_next[0] : 1'b1;
        end
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            rx_state_reg <= RX_IDLE;
            tx_state_reg <= TX_IDLE;
            rcnt_reg     <= 4'h0;
            rbit_reg     <= 4'h0;
            tcnt_reg     <= 4'h0;
            tbit_reg     <= 4'h0;
            rsh_reg      <= 9'h000;
            tsh_reg      <= 11'h7FF;
            rx_valid     <= 1'b0;
            rx_word      <= '0;
            tx_done      <= 1'b0;
            txd          <= 1'b1;
            rxd_out      <= 1'b1;
            rxd_oe       <= 1'b0;
        end
        else
        begin
            rx_state_reg <= rx_state_next;
            tx_state_reg <= tx_state_next;
            rcnt_reg     <= rcnt_next;
            rbit_reg     <= rbit_next;
            tcnt_reg     <= tcnt_next;
            tbit_reg     <= tbit_next;
            rsh_reg      <= rsh_next;
            tsh_reg      <= tsh_next;
            rx_valid     <= rx_valid_next;
            rx_word      <= rx_word_next;
            tx_done      <= tx_done_next;
            txd          <= txd_next;
            rxd_out      <= rxd_out_next;
            rxd_oe       <= rxd_oe_next;
        end
    end

endmodule : uaf_chan
`default_nettype wire

// ---- verif/uaf_checker_assertions.sv ----
// Checker of bus timing and reset state of the serial port
`timescale 1ns/1ps
`default_nettype none
module uaf_checker (
    input wire logic        clk,
    input wire logic        rst,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic [11:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic [1:0]  txd,
    input wire logic        irq
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    a_ready_next: assert property (psel && !penable |=> pready)
        else $error("pready missing after setup");
    a_ready_once: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    a_err_ready: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    a_upper_zero: assert property (pready |-> prdata[31:8] == 24'h00_0000)
        else $error("prdata upper bits not zero");
    a_misalign_err: assert property (psel && !penable && paddr[1:0] != 2'b00 |=> pslverr)
        else $error("misaligned access accepted");
    a_data_hold: assert property (!(psel && !penable) |=> $stable(prdata))
        else $error("prdata moved outside setup");
    a_err_cause: assert property ($rose(pslverr) |-> $past(psel && !penable))
        else $error("pslverr without setup");
    a_reset_quiet: assert property ($fell(rst) |-> txd == 2'b11 && !irq)
        else $error("outputs not idle after reset");
endmodule : uaf_checker
`default_nettype wire

// ---- verif/uaf_node.sv ----
// Far serial node driving frames onto one receive line
`timescale 1ns/1ps
`default_nettype none
module uaf_node (
    input  wire logic clk,
    input  wire logic tick,
    output var  logic line
);
    initial line = 1'b1;
    // One bit lasts 16 oversampling ticks
    task automatic put(input logic b);
        int n;
        line <= b;
        n = 0;
        while (n < 16)
        begin
            @(posedge clk);
            if (tick) n++;
        end
    endtask : put
    // Ninth bit is 1 for an address frame and 0 for data
    task automatic send(input logic nin, input logic [7:0] d);
        put(1'b0);
        for (int i = 0; i < 8; i++)
            put(d[i]);
        put(nin);
        put(1'b1);
    endtask : send
endmodule : uaf_node
`default_nettype wire

// ---- verif/uart_multiproc_address_filter_tb.sv ----
// Register-level bench of the multiprocessor serial port
`timescale 1ns/1ps
`default_nettype none
module uart_multiproc_address_filter_tb;
    import uaf_pkg::*;
    logic        clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000, prdata, rv;
    logic        pready, pslverr, irq, err;
    logic [1:0]  tick = 2'b00, rxd_out, rxd_oe, txd;
    wire  [1:0]  line;
    logic [8:0]  fr [5] = '{9'h0C2, 9'h1C1, 9'h1C2, 9'h1FF, 9'h0FF};
    logic [4:0]  acc = 5'b01100;
    int          miscompares = 0, checked = 0, n;
    always #20 clk = ~clk;
    always @(posedge clk) tick <= ~tick;
    assign line[1] = 1'b1;
    uaf_node node (.clk(clk), .tick(tick[0]), .line(line[0]));
    uaf_top DUT (.clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .rate_tick(tick), .rxd_pin(line), .rxd_out(rxd_out), .rxd_oe(rxd_oe), .txd(txd),
        .irq(irq));
    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check
    task automatic tally_and_finish;
        $display("compares %0d mismatches %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : tally_and_finish
    // Idle edge after release so psel never toggles twice in one step
    task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int k;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        for (k = 0; k == 0 || (!pready && k < 50); k++)
            @(posedge clk);
        if (k >= 50)
            check("pready", 32'h0000_0000, 32'h0000_0001);
        rv = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask : xfer
    // ====================
    // Test sequence
    initial
    begin
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        foreach (fr[i])
        begin
            xfer(1'b0, 12'h420 + 12'(i * 4), 32'h0000_0000);
            check("reset", rv, 32'h0000_0000);
        end
        xfer(1'b0, 12'h421, 32'h0000_0000);
        check("slverr", {31'h0000_0000, err}, 32'h0000_0001);
        $display("test reset done");
        xfer(1'b1, OFS_IMASK, 32'h0000_0001);
        xfer(1'b1, OFS_CTRL0, 32'h0000_00F0);
        node.send(1'b1, 8'h5A);
        xfer(1'b0, OFS_CTRL0, 32'h0000_0000);
        check("ctrl0", rv, 32'h0000_00F5);
        xfer(1'b0, OFS_DATA0, 32'h0000_0000);
        check("data0", rv, 32'h0000_005A);
        check("irq", {31'h0000_0000, irq}, 32'h0000_0001);
        xfer(1'b1, OFS_ISTAT, 32'h0000_0001);
        repeat (2) @(posedge clk);
        check("irq", {31'h0000_0000, irq}, 32'h0000_0000);
        $display("test receive done");
        xfer(1'b1, OFS_ADDR0, 32'h0000_00C0);
        xfer(1'b1, OFS_MASK0, 32'h0000_00FD);
        foreach (fr[i])
        begin
            xfer(1'b1, OFS_CTRL0, 32'h0000_00F0);
            node.send(fr[i][8], fr[i][7:0]);
            xfer(1'b0, OFS_CTRL0, 32'h0000_0000);
            check("filter", rv, acc[i] ? 32'h0000_00F5 : 32'h0000_00F0);
        end
        $display("test filter done");
        xfer(1'b1, OFS_CTRL0, 32'h0000_0070);
        node.send(1'b1, 8'h22);
        xfer(1'b0, OFS_CTRL0, 32'h0000_0000);
        check("mode1 stop ok", rv, 32'h0000_0075);
        xfer(1'b1, OFS_CTRL0, 32'h0000_0070);
        node.send(1'b0, 8'h11);
        xfer(1'b0, OFS_CTRL0, 32'h0000_0000);
        check("mode1 stop bad", rv, 32'h0000_0070);
        $display("test eight-bit stop done");
        xfer(1'b1, OFS_CTRL0, 32'h0000_00E0);
        node.send(1'b1, 8'hFF);
        xfer(1'b0, OFS_CTRL0, 32'h0000_0000);
        check("rx off", rv, 32'h0000_00E0);
        xfer(1'b1, OFS_DATA0, 32'h0000_0033);
        for (n = 0; n < 200 && rv[1] !== 1'b1; n++)
            xfer(1'b0, OFS_CTRL0, 32'h0000_0000);
        check("tx done", {31'h0000_0000, rv[1]}, 32'h0000_0001);
        $display("test disable and transmit done");
        tally_and_finish();
    end
endmodule : uart_multiproc_address_filter_tb
bind uaf_top uaf_checker chk (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
    .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr), .txd(txd), .irq(irq));
`default_nettype wire
